// File: fdc_cfg.svh
// Constants for the floppy command engine: register map, fields, timing
`ifndef FDC_CFG_SVH
`define FDC_CFG_SVH
`define A_CMD      8'h00
`define A_STAT     8'h04
`define A_DATA     8'h08
`define A_CTRL     8'h0C
`define A_IRQ      8'h10
`define A_MASK     8'h14
`define A_TRACK    8'h18
`define CTRL_ETR   0
`define CTRL_DMA   1
`define IRQ_DONE   0
`define IRQ_DATA   1
`define IRQ_SEEK   2
`define IRQ_W      3
`define RES_BYTES  4'd7
`define INV_ST0    8'h80
`define ST0_ABN    8'h40
`define ST1_OVR    8'h10
`define ST2_HIT    8'h08
`define ST2_MISS   8'h04
`define TRK_MSN_LO 4
`define STEP_US    3
`define PULSE_NS   1000
`define CLK_MHZ    200
`endif

// File: fdc_pkg.sv
// Types shared by the floppy command engine
`default_nettype none
package fdc_pkg;
  typedef enum logic [2:0] {S_CMD, S_STEP, S_WAITID, S_XFER, S_RESULT} state_t;
  typedef enum logic [3:0] {C_RDDEL, C_RDID, C_RDTRK, C_RECAL, C_RELSEEK,
                            C_SCANEQ, C_SCANHI, C_SCANLO, C_SEEK, C_INVALID} cmd_t;
endpackage
`default_nettype wire

// File: fdc_cmd_engine.sv
// Floppy command engine: read/scan/seek command phases behind an APB slave
// Function
// - Read-deleted opcode flags, then eight parameter bytes
// - Read-ID returns first ID header found
// - Read-track takes eight parameters, streams track data
// - Recalibrate steps out until track zero
// - Recalibrate and seeks have no result bytes
// - Relative seek steps count tracks by direction
// - Scans compare host bytes with disk bytes
// - Seek steps head to new track number
// - Extended range adds upper track nibble byte
//
// The APB register port and the register addresses are this design's own decisions.
`include "fdc_cfg.svh"
`default_nettype none
module fdc_cmd_engine #(
  parameter int STEP_CYCLES  = `STEP_US * `CLK_MHZ,
  parameter int PULSE_CYCLES = (`PULSE_NS * `CLK_MHZ) / 1000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rdValid,     // Byte from the data separator
  input  wire logic [7:0]  rdByte,
  input  wire logic        rdIsId,      // Byte belongs to an ID field
  input  wire logic        rdLast,      // Last byte of sector or track
  input  wire logic        trackZero,   // Head sits on track 0
  output logic             stepPulse,
  output logic             stepIn,      // 1 steps inward
  output logic [1:0]       driveSel,
  output logic             headSel,
  output logic             dmaReq,
  input  wire logic        dmaAck,
  input  wire logic [7:0]  dmaWrData,   // Host byte for scans
  output logic [7:0]       dmaRdData,   // Disk byte for reads
  output logic             irq
);
  import fdc_pkg::*;

  state_t      state;
  fdc_pkg::cmd_t kind;                 // Decoded command
  logic [7:0]  cmdBytes [0:8];          // Command and parameter bytes
  logic [3:0]  cmdCount;                // Bytes taken so far
  logic [3:0]  cmdNeed;                 // Bytes this command needs
  logic [7:0]  res [0:6];               // Result bytes
  logic [3:0]  resIdx;
  logic [3:0]  resLen;
  logic [11:0] track;                   // Present track
  logic [11:0] stepsLeft;
  logic [31:0] stepTimer;
  logic [1:0]  idCnt;
  logic [7:0]  dataReg;                 // Disk byte awaiting host
  logic        dataFull;
  logic [7:0]  hostReg;                 // Host byte awaiting compare
  logic        hostFull;
  logic        overrun;
  logic        scanMiss;
  logic        extended_track_range;
  logic        dmaEn;
  logic [`IRQ_W-1:0] irqStat;
  logic [`IRQ_W-1:0] irqMask;
  logic [`IRQ_W-1:0] irqSet;

  // APB completion strobes; side effects happen only at the completing edge
  logic xfer, wr, rd;
  assign xfer = psel & penable & pready;
  assign wr   = xfer & pwrite;
  assign rd   = xfer & ~pwrite;
  logic cmdWr, cmdRd, dataWr, dataRd, isScan, hostTake, hostGive;
  assign cmdWr    = wr & (paddr == `A_CMD) & (state == S_CMD);
  assign cmdRd    = rd & (paddr == `A_CMD) & (state == S_RESULT);
  assign dataRd   = rd & (paddr == `A_DATA);
  assign dataWr   = wr & (paddr == `A_DATA);
  assign isScan   = (kind == C_SCANEQ) | (kind == C_SCANHI) | (kind == C_SCANLO);
  assign hostTake = dataRd | (dmaAck & ~isScan);    // Host drains a disk byte
  assign hostGive = dataWr | (dmaAck & isScan);     // Host supplies a scan byte
  logic diskByte, overNow, missNow;
  assign diskByte = rdValid & ((kind == C_RDTRK) | ~rdIsId);  // Byte the command consumes
  assign overNow  = isScan ? ~hostFull : (dataFull & ~hostTake);
  // Compare for this byte; the closing byte must still reach the result
  assign missNow  = isScan & hostFull & (kind == C_SCANEQ ? hostReg != rdByte :
                    kind == C_SCANHI ? rdByte < hostReg : rdByte > hostReg);

  // Opcode decode; relative seek is seek with the top bit set, bit 6 choosing direction
  function automatic fdc_pkg::cmd_t decode(input logic [7:0] op);
    if (op[7] && op[5:0] == 6'h0F) begin
      return C_RELSEEK;
    end
    unique case (op[4:0])
      5'h0C:   return C_RDDEL;
      5'h0A:   return (op[7:5] == 3'h0 || op[7:5] == 3'h2) ? C_RDID : C_INVALID;
      5'h02:   return (op[7] == 1'b0 && op[5] == 1'b0) ? C_RDTRK : C_INVALID;
      5'h07:   return (op[7:5] == 3'h0) ? C_RECAL : C_INVALID;
      5'h11:   return C_SCANEQ;
      5'h1D:   return C_SCANHI;
      5'h19:   return C_SCANLO;
      5'h0F:   return (op[7:5] == 3'h0) ? C_SEEK : C_INVALID;
      default: return C_INVALID;
    endcase
  endfunction

  // Byte count per command; seek grows by one under extended range
  function automatic logic [3:0] needOf(input fdc_pkg::cmd_t k, input logic e);
    unique case (k)
      C_RDID, C_RECAL: return 4'd2;
      C_RELSEEK:       return 4'd3;
      C_SEEK:          return e ? 4'd4 : 4'd3;
      C_INVALID:       return 4'd1;
      default:         return 4'd9;
    endcase
  endfunction

  // Target track; the upper nibble byte keeps its low four bits zero
  logic [11:0] target;
  assign target = extended_track_range ? {cmdBytes[3][7:`TRK_MSN_LO], cmdBytes[2]}
                      : {4'h0, cmdBytes[2]};

  // Command phase collection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdCount <= 4'd0;
      cmdNeed  <= 4'd1;
      kind     <= C_INVALID;
      for (int i = 0; i < 9; i++) cmdBytes[i] <= 8'h00;
    end else if (cmdWr && cmdCount < 4'd9) begin
      cmdBytes[cmdCount] <= pwdata[7:0];
      cmdCount           <= cmdCount + 4'd1;
      if (cmdCount == 4'd0) begin
        kind    <= decode(pwdata[7:0]);
        cmdNeed <= needOf(decode(pwdata[7:0]), extended_track_range);
      end
    end else if (state != S_CMD) begin
      cmdCount <= 4'd0;                 // Ready for the next command
    end
  end

  // Main sequencer: launch, stepping, ID wait, transfer, result phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_CMD;
      track     <= 12'h000;
      stepsLeft <= 12'h000;
      stepTimer <= 32'h0000_0000;
      stepPulse <= 1'b0;
      stepIn    <= 1'b0;
      driveSel  <= 2'h0;
      headSel   <= 1'b0;
      idCnt     <= 2'h0;
      resIdx    <= 4'h0;
      resLen    <= 4'h0;
      overrun   <= 1'b0;
      scanMiss  <= 1'b0;
      irqSet    <= '0;
      for (int i = 0; i < 7; i++) res[i] <= 8'h00;
    end else begin
      irqSet <= '0;
      unique case (state)
        S_CMD: begin
          if (cmdCount != 4'd0 && cmdCount == cmdNeed) begin
            driveSel  <= cmdBytes[1][1:0];
            headSel   <= cmdBytes[1][2];
            overrun   <= 1'b0;
            scanMiss  <= 1'b0;
            idCnt     <= 2'h0;
            stepTimer <= 32'h0000_0000;
            resIdx    <= 4'h0;
            unique case (kind)
              C_RECAL: begin
                stepIn <= 1'b0;
                state  <= S_STEP;
              end
              C_RELSEEK: begin
                stepIn    <= cmdBytes[0][6];
                stepsLeft <= {4'h0, cmdBytes[2]};
                state     <= S_STEP;
              end
              C_SEEK: begin
                stepIn    <= target > track;
                stepsLeft <= (target > track) ? target - track : track - target;
                state     <= S_STEP;
              end
              C_RDID: state <= S_WAITID;
              C_INVALID: begin
                res[0] <= `INV_ST0;
                resLen <= 4'd1;
                state  <= S_RESULT;
                irqSet[`IRQ_DONE] <= 1'b1;
              end
              default: state <= S_XFER;
            endcase
          end
        end
        S_STEP: begin
          // Pulse width is fixed; the timer also spaces successive steps
          if (stepTimer != 32'h0000_0000) begin
            stepTimer <= stepTimer - 32'd1;
            if (stepTimer <= 32'(STEP_CYCLES - PULSE_CYCLES)) stepPulse <= 1'b0;
          end else if (kind == C_RECAL ? trackZero : stepsLeft == 12'h000) begin
            if (kind == C_RECAL) track <= 12'h000;
            stepPulse <= 1'b0;
            state     <= S_CMD;
            irqSet[`IRQ_SEEK] <= 1'b1;
          end else begin
            stepPulse <= 1'b1;
            stepTimer <= 32'(STEP_CYCLES - 1);
            if (kind != C_RECAL) stepsLeft <= stepsLeft - 12'h001;
            track <= stepIn ? track + 12'h001 : track - 12'h001;
          end
        end
        S_WAITID: begin
          // The first four ID bytes seen become result bytes 3 to 6
          if (rdValid && rdIsId) begin
            res[3 + idCnt] <= rdByte;
            idCnt          <= idCnt + 2'h1;
            if (idCnt == 2'h3) begin
              res[0] <= {5'h00, headSel, driveSel};
              res[1] <= 8'h00;
              res[2] <= 8'h00;
              resLen <= `RES_BYTES;
              state  <= S_RESULT;
              irqSet[`IRQ_DONE] <= 1'b1;
            end
          end
        end
        S_XFER: begin
          // Track reads keep every byte; others skip ID fields
          if (diskByte) begin
            if (overNow) overrun <= 1'b1;   // Host too slow: byte lost
            if (missNow) scanMiss <= 1'b1;
            if (rdLast) begin
              res[0] <= ((overrun | overNow) ? `ST0_ABN : 8'h00) | {5'h00, headSel, driveSel};
              res[1] <= (overrun | overNow) ? `ST1_OVR : 8'h00;
              res[2] <= !isScan ? 8'h00 : ((scanMiss | missNow) ? `ST2_MISS : `ST2_HIT);
              res[3] <= cmdBytes[2];
              res[4] <= cmdBytes[3];
              res[5] <= cmdBytes[4];
              res[6] <= cmdBytes[5];
              resLen <= `RES_BYTES;
              state  <= S_RESULT;
              irqSet[`IRQ_DONE] <= 1'b1;
            end
          end
        end
        S_RESULT: begin
          if (cmdRd) begin
            resIdx <= resIdx + 4'd1;
            if (resIdx + 4'd1 == resLen) state <= S_CMD;
          end
        end
        default: state <= S_CMD;
      endcase
    end
  end

  // Data path between disk and host, by register or by DMA
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataReg   <= 8'h00;
      dataFull  <= 1'b0;
      hostReg   <= 8'h00;
      hostFull  <= 1'b0;
      dmaReq    <= 1'b0;
      dmaRdData <= 8'h00;
    end else begin
      if (state == S_XFER && !isScan && rdValid && (kind == C_RDTRK || !rdIsId)) begin
        dataReg   <= rdByte;
        dmaRdData <= rdByte;
        dataFull  <= 1'b1;
      end else if (hostTake) begin
        dataFull <= 1'b0;
      end
      if (state == S_XFER && isScan && rdValid && !rdIsId) hostFull <= 1'b0;
      else if (hostGive) begin
        hostReg  <= dmaAck ? dmaWrData : pwdata[7:0];
        hostFull <= 1'b1;
      end
      // Request drops while acknowledged to avoid a double transfer
      dmaReq <= dmaEn & (state == S_XFER) & ~dmaAck & (isScan ? ~hostFull : dataFull);
    end
  end

  // Control, interrupt status and mask; a new event beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extended_track_range     <= 1'b0;
      dmaEn   <= 1'b0;
      irqStat <= '0;
      irqMask <= '0;
      irq     <= 1'b0;
    end else begin
      if (wr && paddr == `A_CTRL) begin
        extended_track_range   <= pwdata[`CTRL_ETR];
        dmaEn <= pwdata[`CTRL_DMA];
      end
      if (wr && paddr == `A_MASK) irqMask <= pwdata[`IRQ_W-1:0];
      irqStat <= (irqStat & ~((wr && paddr == `A_IRQ) ? pwdata[`IRQ_W-1:0] : '0))
               | irqSet
               | ((state == S_XFER && !isScan && rdValid && (kind == C_RDTRK || !rdIsId))
                  ? (`IRQ_W)'(1 << `IRQ_DATA) : '0);
      irq <= |(irqStat & irqMask);
    end
  end

  // APB answer: one wait state, read data and error from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        unique case (paddr)
          `A_CMD: begin
            prdata  <= {24'h0, res[resIdx[2:0]]};
            pslverr <= pwrite ? (state != S_CMD) : (state != S_RESULT);
          end
          `A_STAT:  prdata <= {24'h0, dataFull, hostFull, 2'h0, state == S_RESULT,
                               state != S_CMD, state == S_CMD, cmdCount != 4'd0};
          `A_DATA:  prdata <= {24'h0, dataReg};
          `A_CTRL:  prdata <= {30'h0, dmaEn, extended_track_range};
          `A_IRQ:   prdata <= {29'h0, irqStat};
          `A_MASK:  prdata <= {29'h0, irqMask};
          `A_TRACK: prdata <= {20'h0, track};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: fdc_cmd_engine_assertions.sv
// Port-level checks for the floppy command engine
`default_nettype none
module fdc_cmd_engine_assertions #(
  parameter int STEP_CYCLES  = 600,
  parameter int PULSE_CYCLES = 200
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stepPulse,
  input wire logic        stepIn
);
  int hiCnt;   // Cycles the step pulse has stood high
  int gapCnt;  // Cycles since the last step began, saturating
  // Pulse width counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hiCnt <= 0;
    else hiCnt <= stepPulse ? hiCnt + 1 : 0;
  end
  // Spacing counter; starts full so the first step is always allowed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gapCnt <= STEP_CYCLES;
    else if (stepPulse && hiCnt == 0) gapCnt <= 1;
    else if (gapCnt < STEP_CYCLES) gapCnt <= gapCnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_first; psel && penable && !pready; endsequence
  property p_one_wait; s_setup ##1 s_first |-> ##1 pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_ready_in; pready |-> psel && penable; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_unmapped;
    pready && (paddr > 8'h18 || paddr[1:0] != 2'b00) |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_pulse_len; !stepPulse && hiCnt != 0 |-> hiCnt == PULSE_CYCLES; endproperty
  property p_step_gap; stepPulse && hiCnt == 0 |-> gapCnt >= STEP_CYCLES; endproperty
  property p_dir_hold; stepPulse && hiCnt != 0 |-> $stable(stepIn); endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");
  a_ready_once: assert property (p_ready_once) else $error("pready held too long");
  a_ready_in: assert property (p_ready_in) else $error("pready outside access");
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_pulse_len: assert property (p_pulse_len) else $error("step pulse width wrong");
  a_step_gap: assert property (p_step_gap) else $error("steps too close");
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved in pulse");
endmodule
bind fdc_cmd_engine fdc_cmd_engine_assertions #(
  .STEP_CYCLES(STEP_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stepPulse(stepPulse), .stepIn(stepIn));
`default_nettype wire

// File: fdc_drive_model.sv
// Drive model: head position and the byte stream off the media
`default_nettype none
module fdc_drive_model (
  input  wire logic       clk,
  input  wire logic       stepPulse,
  input  wire logic       stepIn,
  output logic            trackZero,
  output logic            rdValid,
  output logic [7:0]      rdByte,
  output logic            rdIsId,
  output logic            rdLast
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cyl = 5;           // Head starts away from track zero
  logic prevStep = 1'b0;   // Edge finder for the step line
  assign trackZero = (cyl == 0);
  // One track per rising step edge; the stop at zero is mechanical
  always @(posedge clk) begin
    prevStep <= stepPulse;
    if (stepPulse && !prevStep) cyl <= stepIn ? cyl + 1 : (cyl > 0 ? cyl - 1 : 0);
  end
  // One byte for one cycle; afterwards the lines show garbage
  task automatic put(input logic [7:0] b, input logic id, input logic last);
    rdByte <= b;
    rdIsId <= id;
    rdLast <= last;
    rdValid <= 1'b1;
    @(posedge clk);
    rdValid <= 1'b0;
    rdByte <= ~b;
    rdIsId <= ~id;
    rdLast <= ~last;
    @(posedge clk);
  endtask
  initial begin
    rdValid = 1'b0;
    rdByte = 8'h00;
    rdIsId = 1'b0;
    rdLast = 1'b0;
  end
endmodule
`default_nettype wire

// File: test_floppy_read_scan_seek_commands.sv
// Self-checking bench for the floppy command engine
`include "fdc_cfg.svh"
`default_nettype none
module test_floppy_read_scan_seek_commands;
  timeunit 1ns;
  timeprecision 100ps;
  import fdc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, rdByte, dmaWrData, dmaRdData;
  logic [31:0] pwdata, prdata, lastRd, seed, d;
  logic        rdValid, rdIsId, rdLast, trackZero, stepPulse, stepIn, headSel, dmaReq;
  logic        dmaAck = 1'b0;
  logic [1:0]  driveSel;
  logic [33:0] notes[$];  // Expected reads: check flag, pslverr, prdata
  int          bad_count, tests_run, cyc, t;
  logic [7:0]  rdOps[2] = '{8'hEC, 8'h42};
  logic [15:0] scOps[3] = '{16'h1104, 16'h1D08, 16'h1904};  // Opcode and expected ST2 hit or miss flag
  // Short step timing keeps long seeks cheap
  fdc_cmd_engine #(.STEP_CYCLES(8), .PULSE_CYCLES(2)) u_dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rdValid(rdValid), .rdByte(rdByte),
    .rdIsId(rdIsId), .rdLast(rdLast), .trackZero(trackZero), .stepPulse(stepPulse),
    .stepIn(stepIn), .driveSel(driveSel), .headSel(headSel), .dmaReq(dmaReq),
    .dmaAck(dmaAck), .dmaWrData(dmaWrData), .dmaRdData(dmaRdData), .irq(irq));
  fdc_drive_model u_drv (.clk(clk), .stepPulse(stepPulse), .stepIn(stepIn),
    .trackZero(trackZero), .rdValid(rdValid), .rdByte(rdByte), .rdIsId(rdIsId), .rdLast(rdLast));
  initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    lastRd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd); xfer(1'b1, a, wd); endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    notes.push_back({1'b1, e});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic waitBit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin notes.push_back(34'h0); xfer(1'b0, a, 32'h0); n++; end
    while (!lastRd[b] && n < 3000);
    chk("wait", lastRd[b], 1);
  endtask
  // Command bytes, then one edge so the launch has reached the outputs
  task automatic cmd(input logic [7:0] b[$]);
    foreach (b[i]) wr(`A_CMD, {24'h0, b[i]});
    @(posedge clk);
  endtask
  task automatic res(input logic [7:0] e[$]); foreach (e[i]) rd(`A_CMD, {25'h0, e[i]}); endtask
  // End of a head move: track, head, no result bytes, interrupt raised then cleared
  task automatic seekDone(input int trk, input logic ie);
    waitBit(`A_IRQ, `IRQ_SEEK);
    chk("irq", irq, ie);
    rd(`A_TRACK, trk);
    chk("head", u_drv.cyl, trk);
    rd(`A_STAT, 33'h2);
    wr(`A_IRQ, 32'h4);
    rd(`A_IRQ, 33'h0);
  endtask
  // Scoreboard: oldest note against each completed read
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      if (notes[0][33]) chk("read", {pslverr, prdata}, notes[0][32:0]);
      void'(notes.pop_front());
    end
  end
  // DMA partner: one acknowledge per request
  always @(posedge clk) dmaAck <= dmaReq && !dmaAck;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin bad_count++; end_of_test(); end
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; dmaWrData = 8'h40; seed = 32'd22;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`A_STAT, 33'h2);
    rd(`A_CTRL, 33'h0);
    rd(`A_MASK, 33'h0);
    rd(8'h1C, 33'h1_0000_0000);
    // Unknown opcode answers with a single status byte
    cmd({8'h00});
    res({8'h80});
    wr(`A_IRQ, 32'h7);
    wr(`A_MASK, 32'h7);
    cmd({8'h07, 8'h00});
    seekDone(0, 1'b1);
    t = 4 + (rnd() % 20);
    cmd({8'h0F, 8'h01, t[7:0]});
    chk("drive", driveSel, 1);
    seekDone(t, 1'b1);
    cmd({8'h8F, 8'h00, 8'h03});
    seekDone(t - 3, 1'b1);
    cmd({8'hCF, 8'h00, 8'h05});
    seekDone(t + 2, 1'b1);
    wr(`A_MASK, 32'h3);
    cmd({8'h0F, 8'h00, t[7:0]});
    seekDone(t, 1'b0);
    wr(`A_MASK, 32'h7);
    wr(`A_CTRL, 32'h1);
    cmd({8'h0F, 8'h00, 8'h05, 8'h10});
    seekDone(261, 1'b1);
    wr(`A_CTRL, 32'h0);
    d = rnd();
    cmd({8'h4A, 8'h01});
    u_drv.put(8'hAA, 1'b0, 1'b0);
    u_drv.put(d[7:0], 1'b1, 1'b0);
    u_drv.put(8'h00, 1'b1, 1'b0);
    u_drv.put(8'h03, 1'b1, 1'b0);
    u_drv.put(8'h02, 1'b1, 1'b0);
    waitBit(`A_IRQ, `IRQ_DONE);
    res({8'h01, 8'h00, 8'h00, d[7:0], 8'h00, 8'h03, 8'h02});
    wr(`A_IRQ, 32'h7);
    // Sector and track reads through the data register
    foreach (rdOps[i]) begin
      d = rnd();
      cmd({rdOps[i], 8'h05, 8'h21, 8'h01, 8'h04, 8'h02, 8'h09, 8'h1B, 8'hFF});
      chk("head select", headSel, 1);
      u_drv.put(d[7:0], 1'b0, 1'b0);
      waitBit(`A_STAT, 7);
      rd(`A_DATA, {25'h0, d[7:0]});
      chk("dma byte", dmaRdData, d[7:0]);
      u_drv.put(d[15:8], 1'b0, 1'b1);
      waitBit(`A_STAT, 7);
      rd(`A_DATA, {25'h0, d[15:8]});
      waitBit(`A_IRQ, `IRQ_DONE);
      res({8'h05, 8'h00, 8'h00, 8'h21, 8'h01, 8'h04, 8'h02});
      wr(`A_IRQ, 32'h7);
    end
    // Scans: host byte 40 by DMA against disk byte 50
    wr(`A_CTRL, 32'h2);
    foreach (scOps[i]) begin
      cmd({scOps[i][15:8], 8'h00, 8'h21, 8'h00, 8'h04, 8'h02, 8'h09, 8'h1B, 8'h01});
      waitBit(`A_STAT, 6);
      u_drv.put(8'h50, 1'b0, 1'b1);
      waitBit(`A_IRQ, `IRQ_DONE);
      res({8'h00, 8'h00, scOps[i][7:0], 8'h21, 8'h00, 8'h04, 8'h02});
      wr(`A_IRQ, 32'h7);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
